/* File: logic/apbp_port.sv */
// parallel host port: byte steering, write assembly, busy timing
`timescale 1ns/1ps
`include "apbp_defs.svh"

// Summary of operation
// - strobes honoured only with chip select low
// - upper select high: upper byte on low pins
// - upper select low write: low byte on pins
// - upper select low read: all twelve bits
// - nine low pins bidirectional, three-state
// - three upper pins output only, three-state
// - unipolar straight binary, bipolar two's complement
// - conversion and calibration timed by master input
// - busy rises on trigger falling edge until done
// - busy high during calibration sequence
// - trigger rising edge holds and starts conversion
// - top two bits pick target, fourteen stored
module apbp_port import apbp_pkg::*; #(
	parameter int CAL_MCLK  = `APBP_CAL_MCLK,
	parameter int CONV_MCLK = `APBP_CONV_MCLK
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// host strobes
	input  wire logic        chip_sel_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        upper_half_select,
	// data pins
	input  wire logic [8:0]  low_bidir_pins_in,
	output logic      [8:0]  low_bidir_pins_out,
	output logic      [8:0]  low_bidir_pins_oe_n,
	output logic      [2:0]  upper_output_pins_out,
	output logic      [2:0]  upper_output_pins_oe_n,
	// converter side
	input  wire logic        master_timing_input,
	input  wire logic        conversion_trigger,
	input  wire logic [11:0] sample_code,
	output logic             hold_mode,
	output logic             busy
);
	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	apbp_state_t  state_ff;
	logic [13:0]  ctrl_ff;
	logic [13:0]  test_ff;
	logic [13:0]  cal_ff;
	logic [11:0]  result_ff;
	logic [7:0]   lo_byte_ff;
	logic         lo_seen_ff;
	logic         wr_n_ff;
	logic         trig_ff;
	logic         mclk_ff;
	logic [12:0]  mcnt_ff;
	logic [15:0]  rd_word_ff;

	logic         wr_rise;
	logic         mclk_rise;
	logic [15:0]  wr_word;
	logic [11:0]  coded;
	logic         drive;

	assign wr_rise   = ~wr_n_ff & wr_n & ~chip_sel_n;
	assign mclk_rise = master_timing_input & ~mclk_ff;
	assign wr_word   = {low_bidir_pins_in[7:0], lo_byte_ff};

	// --------------------------------------------------------------
	// data coding
	// --------------------------------------------------------------
	// bipolar flips the msb of an offset-binary code into two's complement
	assign coded     = ctrl_ff[`APBP_CTRL_BIPOLAR] ?
		{~sample_code[11], sample_code[10:0]} : sample_code;

	// --------------------------------------------------------------
	// input sampling for edge detection
	// --------------------------------------------------------------
	// reset to idle levels, so leaving reset shows no false strobe edge
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wr_n_ff <= 1'b1;
			trig_ff <= 1'b1;
			mclk_ff <= 1'b0;
		end else begin
			wr_n_ff <= wr_n;
			trig_ff <= conversion_trigger;
			mclk_ff <= master_timing_input;
		end
	end

	// --------------------------------------------------------------
	// write assembly: low byte then high byte
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			lo_byte_ff <= 8'h00;
			lo_seen_ff <= 1'b0;
			ctrl_ff    <= `APBP_CTRL_RST;
			test_ff    <= 14'h0000;
			cal_ff     <= 14'h0000;
		end else begin
			if (state_ff == APBP_CAL)
				ctrl_ff[`APBP_CTRL_CAL_START] <= 1'b0;
			// a high byte without a low byte before it is dropped, not merged
			if (wr_rise && !upper_half_select) begin
				lo_byte_ff <= low_bidir_pins_in[7:0];
				lo_seen_ff <= 1'b1;
			end else if (wr_rise && upper_half_select && lo_seen_ff) begin
				lo_seen_ff <= 1'b0;
				case (wr_word[`APBP_ADDR_MSB:`APBP_ADDR_LSB])
				`APBP_ADDR_TEST: test_ff <= wr_word[13:0];
				`APBP_ADDR_CAL:  cal_ff  <= wr_word[13:0];
				`APBP_ADDR_CTRL: ctrl_ff <= wr_word[13:0];
				default: ;
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// conversion and calibration sequencer, busy
	// --------------------------------------------------------------
	// a 13-bit count covers the longest calibration count
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_ff  <= APBP_IDLE;
			mcnt_ff   <= 13'h0000;
			result_ff <= 12'h000;
			hold_mode <= 1'b0;
		end else begin
			case (state_ff)
			APBP_IDLE: begin
				// a trigger edge wins over a pending calibration start
				if (trig_ff && !conversion_trigger) begin
					state_ff <= APBP_CONV;
					mcnt_ff  <= 13'h0000;
				end else if (ctrl_ff[`APBP_CTRL_CAL_START]) begin
					state_ff <= APBP_CAL;
					mcnt_ff  <= 13'h0000;
				end
			end
			APBP_CONV: begin
				// hold is taken on the rising edge that ends the trigger pulse
				if (!trig_ff && conversion_trigger)
					hold_mode <= 1'b1;
				if (hold_mode && mclk_rise)
					mcnt_ff <= mcnt_ff + 13'h0001;
				if (hold_mode && mcnt_ff == 13'(CONV_MCLK)) begin
					result_ff <= coded;
					hold_mode <= 1'b0;
					state_ff  <= APBP_IDLE;
				end
			end
			APBP_CAL: begin
				if (mclk_rise)
					mcnt_ff <= mcnt_ff + 13'h0001;
				if (mcnt_ff == 13'(CAL_MCLK))
					state_ff <= APBP_IDLE;
			end
			default: state_ff <= APBP_IDLE;
			endcase
		end
	end

	// busy drops on the edge that stores the result, so a read right after sees it
	always_ff @(posedge clk_sys) begin
		if (!nrst)
			busy <= 1'b0;
		else if (state_ff == APBP_IDLE)
			busy <= trig_ff && !conversion_trigger;
		else
			busy <= !((state_ff == APBP_CONV && hold_mode && mcnt_ff == 13'(CONV_MCLK))
				|| (state_ff == APBP_CAL && mcnt_ff == 13'(CAL_MCLK)));
	end

	// --------------------------------------------------------------
	// read path; calibration words come out in two reads, twelve bits then the upper byte
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rd_word_ff  <= 16'h0000;
		end else begin
			// test and calibration readback carry their address in the top bits
			case (apbp_rdsel_t'(ctrl_ff[`APBP_CTRL_RDSEL_LSB +: 2]))
			APBP_RD_RESULT: rd_word_ff <= {4'h0, result_ff};
			APBP_RD_TEST:   rd_word_ff <= {`APBP_ADDR_TEST, test_ff};
			APBP_RD_CAL:    rd_word_ff <= {`APBP_ADDR_CAL, cal_ff};
			APBP_RD_STATUS: rd_word_ff <= {1'b0, busy, ctrl_ff};
			default:        rd_word_ff <= 16'h0000;
			endcase
		end
	end

	// --------------------------------------------------------------
	// pin drivers
	// --------------------------------------------------------------
	// enables are registered with the data, so pins turn on a cycle after the strobe
	assign drive = ~chip_sel_n & ~rd_n;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			low_bidir_pins_out     <= 9'h000;
			upper_output_pins_out  <= 3'h0;
			low_bidir_pins_oe_n    <= 9'h1ff;
			upper_output_pins_oe_n <= 3'h7;
		end else begin
			low_bidir_pins_oe_n    <= {9{~drive}};
			upper_output_pins_oe_n <= {3{~(drive & ~upper_half_select)}};
			if (upper_half_select) begin
				low_bidir_pins_out    <= {1'b0, rd_word_ff[15:8]};
				upper_output_pins_out <= 3'h0;
			end else begin
				low_bidir_pins_out    <= rd_word_ff[8:0];
				upper_output_pins_out <= rd_word_ff[11:9];
			end
		end
	end
endmodule : apbp_port

/* File: logic/apbp_defs.svh */
// timing counts and field positions for the parallel byte port
`ifndef APBP_DEFS_SVH
`define APBP_DEFS_SVH
`define APBP_SYS_CLK_HZ      200000000
`define APBP_MCLK_FAST_HZ    4000000
`define APBP_MCLK_LP_HZ      1800000
`define APBP_CONV_MCLK       18
`define APBP_CAL_MCLK        4096
`define APBP_ADDR_MSB        15
`define APBP_ADDR_LSB        14
`define APBP_ADDR_NONE       2'h0
`define APBP_ADDR_TEST       2'h1
`define APBP_ADDR_CAL        2'h2
`define APBP_ADDR_CTRL       2'h3
`define APBP_CTRL_RDSEL_LSB  6
`define APBP_CTRL_BIPOLAR    4
`define APBP_CTRL_CAL_START  2
`define APBP_CTRL_RST        14'h0000
`endif

/* File: logic/apbp_pkg.sv */
// types for the parallel byte port
package apbp_pkg;
	typedef enum logic [1:0] {
		APBP_IDLE = 2'b00,
		APBP_CONV = 2'b01,
		APBP_CAL  = 2'b10
	} apbp_state_t;
	typedef enum logic [1:0] {
		APBP_RD_RESULT = 2'b00,
		APBP_RD_TEST   = 2'b01,
		APBP_RD_CAL    = 2'b10,
		APBP_RD_STATUS = 2'b11
	} apbp_rdsel_t;
endpackage : apbp_pkg

/* File: verification/apbp_port_assertions.sv */
// checker for the parallel byte port
`timescale 1ns/1ps
module apbp_port_checker (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// host strobes
	input wire logic        chip_sel_n,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic        upper_half_select,
	// data pins
	input wire logic [8:0]  low_bidir_pins_in,
	input wire logic [8:0]  low_bidir_pins_out,
	input wire logic [8:0]  low_bidir_pins_oe_n,
	input wire logic [2:0]  upper_output_pins_out,
	input wire logic [2:0]  upper_output_pins_oe_n,
	// converter side
	input wire logic        master_timing_input,
	input wire logic        conversion_trigger,
	input wire logic [11:0] sample_code,
	input wire logic        hold_mode,
	input wire logic        busy
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire logic sel_rd = !chip_sel_n && !rd_n;
	a_drive_needs_rd: assert property (low_bidir_pins_oe_n != 9'h1ff |-> $past(sel_rd))
		else $error("low pins driven outside read");
	a_rd_drives_low: assert property ($past(sel_rd) |-> low_bidir_pins_oe_n[7:0] == 8'h00)
		else $error("low pins idle in read");
	a_upper_needs_lo: assert property (upper_output_pins_oe_n != 3'h7 |->
		$past(sel_rd && !upper_half_select)) else $error("upper pins driven wrongly");
	a_wide_read_all: assert property ($past(sel_rd && !upper_half_select) |->
		{upper_output_pins_oe_n, low_bidir_pins_oe_n} == 12'h000) else $error("not all 12");
	a_busy_on_fall: assert property ($fell(conversion_trigger) |-> ##[1:3] busy)
		else $error("busy late");
	a_hold_on_rise: assert property ($rose(conversion_trigger) && busy |-> ##[1:2] hold_mode)
		else $error("hold late");
	a_hold_in_busy: assert property (hold_mode |-> busy)
		else $error("hold without busy");
	a_conv_bounded: assert property ($rose(hold_mode) |-> ##[1:400] !busy)
		else $error("conversion too long");
	c_upper_read: cover property ($past(sel_rd) && upper_half_select);
	c_conv_done: cover property ($fell(hold_mode));
	c_cal_done: cover property ($fell(busy) && !$past(hold_mode));
endmodule : apbp_port_checker
bind apbp_port apbp_port_checker chk (
	.clk_sys                (clk_sys),
	.nrst                   (nrst),
	.chip_sel_n             (chip_sel_n),
	.rd_n                   (rd_n),
	.wr_n                   (wr_n),
	.upper_half_select      (upper_half_select),
	.low_bidir_pins_in      (low_bidir_pins_in),
	.low_bidir_pins_out     (low_bidir_pins_out),
	.low_bidir_pins_oe_n    (low_bidir_pins_oe_n),
	.upper_output_pins_out  (upper_output_pins_out),
	.upper_output_pins_oe_n (upper_output_pins_oe_n),
	.master_timing_input    (master_timing_input),
	.conversion_trigger     (conversion_trigger),
	.sample_code            (sample_code),
	.hold_mode              (hold_mode),
	.busy                   (busy)
);

/* File: verification/apbp_host_model.sv */
// host processor model on the parallel bus
`timescale 1ns/1ps
module apbp_host_model (
	// clock and sampled pins
	input  wire logic        clk_sys,
	input  wire logic [11:0] pins,
	// host strobes and driven data
	output logic             chip_sel_n,
	output logic             rd_n,
	output logic             wr_n,
	output logic             upper_half_select,
	output logic      [8:0]  host_dq
);
	logic [11:0] q;
	initial begin
		{chip_sel_n, rd_n, wr_n, upper_half_select, host_dq} = 13'h1e00;
	end
	// strobe qualified by select and half select, held three cycles
	task automatic acc(input logic s, r, h, input logic [7:0] b);
		@(negedge clk_sys);
		chip_sel_n = !s;
		upper_half_select = h;
		host_dq = r ? ~host_dq : {1'b0, b};
		if (r) rd_n = 0; else wr_n = 0;
		repeat (3) @(negedge clk_sys);
		q = pins;
		rd_n = 1;
		wr_n = 1;
		@(negedge clk_sys);
		chip_sel_n = 1;
		// released bus floats, so never leave the last value standing
		host_dq = ~host_dq;
	endtask : acc
	// low byte first, high byte commits
	task automatic wr16(input logic s, input logic [15:0] w);
		acc(s, 0, 0, w[7:0]);
		acc(s, 0, 1, w[15:8]);
	endtask : wr16
endmodule : apbp_host_model

/* File: verification/test_adc_parallel_byte_port.sv */
// testbench for the parallel byte port
`timescale 1ns/1ps
module test_adc_parallel_byte_port;
	logic clk_sys, nrst, chip_sel_n, rd_n, wr_n, upper_half_select, hold_mode, busy;
	logic master_timing_input, conversion_trigger;
	logic [8:0] host_dq, low_bidir_pins_in, low_bidir_pins_out, low_bidir_pins_oe_n;
	logic [2:0] upper_output_pins_out, upper_output_pins_oe_n;
	logic [11:0] sample_code, pins;
	int bad_count, compares;
	// upper pins pulled up when nobody drives them
	assign low_bidir_pins_in = (low_bidir_pins_out & ~low_bidir_pins_oe_n)
		| (host_dq & low_bidir_pins_oe_n);
	assign pins = {upper_output_pins_out & ~upper_output_pins_oe_n | upper_output_pins_oe_n,
		low_bidir_pins_in};
	apbp_port #(
		.CAL_MCLK  (8),
		.CONV_MCLK (4)
	) uut (
		.clk_sys                (clk_sys),
		.nrst                   (nrst),
		.chip_sel_n             (chip_sel_n),
		.rd_n                   (rd_n),
		.wr_n                   (wr_n),
		.upper_half_select      (upper_half_select),
		.low_bidir_pins_in      (low_bidir_pins_in),
		.low_bidir_pins_out     (low_bidir_pins_out),
		.low_bidir_pins_oe_n    (low_bidir_pins_oe_n),
		.upper_output_pins_out  (upper_output_pins_out),
		.upper_output_pins_oe_n (upper_output_pins_oe_n),
		.master_timing_input    (master_timing_input),
		.conversion_trigger     (conversion_trigger),
		.sample_code            (sample_code),
		.hold_mode              (hold_mode),
		.busy                   (busy)
	);
	apbp_host_model host (
		.clk_sys           (clk_sys),
		.pins              (pins),
		.chip_sel_n        (chip_sel_n),
		.rd_n              (rd_n),
		.wr_n              (wr_n),
		.upper_half_select (upper_half_select),
		.host_dq           (host_dq)
	);
	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// 4 MHz master timing input
	initial begin
		master_timing_input = 0;
		forever #125 master_timing_input = ~master_timing_input;
	end
	task automatic summarize;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	task automatic chk(input logic [11:0] s, e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		if (busy !== 1'b0) begin
			bad_count++;
			summarize();
		end
	endtask : wait_idle
	task automatic conv(input logic [11:0] c, e);
		sample_code = c;
		conversion_trigger = 0;
		repeat (3) @(negedge clk_sys);
		chk({11'h000, busy}, 12'h001);
		conversion_trigger = 1;
		wait_idle();
		host.acc(1, 1, 0, 8'h00);
		chk(host.q, e);
		host.acc(1, 1, 1, 8'h00);
		chk(host.q, {8'hE0, e[11:8]});
	endtask : conv
	// writes by address, refused writes, readback through the test, calibration and status read selects
	task automatic regs;
		host.wr16(1, 16'h8123);
		host.wr16(1, 16'h4ABC);
		host.wr16(1, 16'h0456);
		host.acc(1, 0, 1, 8'h40);
		host.wr16(1, 16'hC040);
		host.acc(1, 1, 0, 8'h00);
		chk(host.q, 12'hABC);
		host.acc(1, 1, 1, 8'h00);
		chk(host.q, 12'hE4A);
		host.wr16(1, 16'hC080);
		host.acc(1, 1, 0, 8'h00);
		chk(host.q, 12'h123);
		host.acc(1, 1, 1, 8'h00);
		chk(host.q, 12'hE81);
		host.wr16(1, 16'hC0C0);
		host.acc(1, 1, 0, 8'h00);
		chk(host.q, 12'h0C0);
		host.wr16(1, 16'hC000);
	endtask : regs
	task automatic calib;
		host.wr16(1, 16'hC004);
		repeat (2) @(negedge clk_sys);
		chk({11'h000, busy}, 12'h001);
		wait_idle();
	endtask : calib
	initial begin
		{nrst, bad_count, compares, sample_code} = 0;
		conversion_trigger = 1;
		repeat (5) @(negedge clk_sys);
		nrst = 1;
		conv(12'h9A5, 12'h9A5);
		host.wr16(0, 16'hC010);
		conv(12'h9A5, 12'h9A5);
		host.wr16(1, 16'hC010);
		conv(12'h9A5, 12'h1A5);
		calib();
		regs();
		conv(12'h3C0, 12'h3C0);
		summarize();
	end
endmodule : test_adc_parallel_byte_port
